// ### design/cgpm_pkg.sv
// shared constants and carrier types of the clock generation and power-mode block
package cgpm_pkg;

	// ****************************************
	// clock modes and power modes
	// ****************************************
	typedef enum logic [2:0] {
		CGPM_MODE_PLL      = 3'h1,
		CGPM_MODE_PRESCALE = 3'h2,
		CGPM_MODE_BASE     = 3'h4
	} cgpm_clk_mode_e;

	typedef enum logic [3:0] {
		CGPM_PM_ACTIVE = 4'h1,
		CGPM_PM_IDLE   = 4'h2,
		CGPM_PM_SLOW   = 4'h4,
		CGPM_PM_DOWN   = 4'h8
	} cgpm_pwr_e;

	// software request encoding on power_mode_req_in
	localparam logic [1:0] CGPM_REQ_ACTIVE = 2'h0;
	localparam logic [1:0] CGPM_REQ_IDLE   = 2'h1;
	localparam logic [1:0] CGPM_REQ_SLOW   = 2'h2;
	localparam logic [1:0] CGPM_REQ_DOWN   = 2'h3;

	// ****************************************
	// divider constants
	// ****************************************
	localparam int unsigned CGPM_OSC_MHZ     = 10;
	localparam int unsigned CGPM_P_DIV       = 1;
	localparam int unsigned CGPM_K_DIV       = 2;
	localparam int unsigned CGPM_N_DEFAULT   = 16;
	localparam logic [3:0]  CGPM_FEEDBACK_DIVIDER_FIELD_RESET  = 4'h2;
	localparam int unsigned CGPM_CPU_DIV     = 3;
	localparam int unsigned CGPM_CNT_W       = 8;
	localparam logic [7:0]  CGPM_CNT_ONE     = 8'h01;
	localparam logic [7:0]  CGPM_CNT_ZERO    = 8'h00;
	localparam logic [7:0]  CGPM_FACT_RESET  = 8'h01;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic       oscillator_disconnect;
		logic       vco_bypass_select;
		logic [3:0] feedback_divider_field;
		logic       vco_range_select;
		logic       toggle_latch_enable;
		logic [7:0] slowdown_factor_field;
		logic [1:0] clock_out_select;
	} cgpm_ctrl_s;

	typedef struct packed {
		logic cpu_core_clock_en;
		logic periph_clock_en;
		logic capture_unit_clock_en;
		logic flash_fast_clock_a_en;
		logic flash_fast_clock_b_en;
	} cgpm_clk_en_s;

	typedef struct packed {
		logic osc_running;
		logic pll_lock_lost;
		logic osc_powered;
		logic pll_powered;
	} cgpm_status_s;

endpackage : cgpm_pkg

// ### design/cgpm_divider.sv
// glitch-free enable divider: one-cycle enable every factor ticks of tick_in
`timescale 1ns/1ps
`default_nettype none
module cgpm_divider
	import cgpm_pkg::*;
#(
	parameter int unsigned WIDTH = CGPM_CNT_W
) (
	input  wire logic             core_clk_in,
	input  wire logic             arst_n_in,
	input  wire logic             tick_in,
	input  wire logic [WIDTH-1:0] factor_in,
	output var  logic             en_out
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             next_en;

	// new factor only taken at period end, so no pulse is shortened
	always_comb begin
		next_count = count;
		next_en    = 1'b0;
		if (tick_in) begin
			if (count <= WIDTH'(1)) begin
				next_count = (factor_in == '0) ? WIDTH'(1) : factor_in;
				next_en    = 1'b1;
			end else begin
				next_count = count - WIDTH'(1);
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count  <= '0;
			en_out <= 1'b0;
		end else begin
			count  <= next_count;
			en_out <= next_en;
		end
	end
endmodule : cgpm_divider
`default_nettype wire

// ### design/cgpm_top.sv
// clock generation and power-mode control: mode select, clock enables, power modes
//
// Functional notes
// - mode from disconnect and bypass bits; disconnect forces PLL base mode
// - PLL base mode: system clock is VCO base frequency over K
// - prescaler mode: oscillator clock divided by P times K
// - PLL mode: oscillator times N over P times K, bypass inactive
// - P fixed at one, K fixed at two, not programmable
// - normal running uses PLL mode
// - detect oscillator running and PLL loss of lock
// - clock source is fixed 10 MHz on-chip oscillator
// - toggle latch halves clock output, 50% duty
// - all module clocks from system clock; CPU and peripherals at third
// - idle stops CPU clock, others keep running
// - slow-down divides CPU and peripherals by common slowdown factor
// - power-down switches off oscillator and PLL
// - after reset enter active mode at main system clock
// - software selects idle, slow-down or power-down from active
`timescale 1ns/1ps
`default_nettype none
module cgpm_top
	import cgpm_pkg::*;
#(
	parameter int unsigned CPU_DIV   = CGPM_CPU_DIV,
	parameter int unsigned LOCK_WAIT = 64
) (
	input  wire logic           core_clk_in,
	input  wire logic           arst_n_in,
	input  wire cgpm_ctrl_s     ctrl_in,
	input  wire logic [1:0]     power_mode_req_in,
	input  wire logic           osc_alive_in,
	input  wire logic           pll_locked_in,
	input  wire logic           wakeup_in,
	output var  cgpm_clk_mode_e clk_mode_out,
	output var  cgpm_pwr_e      power_mode_out,
	output var  cgpm_clk_en_s   clk_en_out,
	output var  cgpm_status_s   status_out,
	output var  logic [7:0]     sys_mult_out,
	output var  logic [7:0]     sys_div_out,
	output var  logic           flash_prog_ok_out,
	output var  logic           clock_output_pin_out
);

	// ****************************************
	// clock mode selection
	// ****************************************
	cgpm_clk_mode_e next_mode;
	logic [7:0]     next_mult;
	logic [7:0]     next_div;

	function automatic logic [7:0] feedback_divider_field_to_n(input logic [3:0] f);
		// field code counts in steps of eight from zero
		feedback_divider_field_to_n = {1'b0, f, 3'h0};
	endfunction : feedback_divider_field_to_n

	always_comb begin
		if (ctrl_in.oscillator_disconnect) begin
			next_mode = CGPM_MODE_BASE;
		end else if (ctrl_in.vco_bypass_select) begin
			next_mode = CGPM_MODE_PRESCALE;
		end else begin
			next_mode = CGPM_MODE_PLL;
		end
		next_div = 8'(CGPM_P_DIV * CGPM_K_DIV);
		case (next_mode)
			CGPM_MODE_BASE: begin
				next_mult = 8'h00;
				next_div  = 8'(CGPM_K_DIV);
			end
			CGPM_MODE_PRESCALE: begin
				next_mult = 8'h01;
			end
			// oscillator times N, reset field gives 80 MHz
			CGPM_MODE_PLL: begin
				next_mult = feedback_divider_field_to_n(ctrl_in.feedback_divider_field);
			end
			default: begin
				next_mult = 8'h01;
			end
		endcase
	end

	// ****************************************
	// power mode state machine
	// ****************************************
	cgpm_pwr_e next_pwr;

	always_comb begin
		next_pwr = power_mode_out;
		case (power_mode_out)
			// only active mode may enter a saving mode
			CGPM_PM_ACTIVE: begin
				case (power_mode_req_in)
					CGPM_REQ_IDLE:  next_pwr = CGPM_PM_IDLE;
					CGPM_REQ_SLOW:  next_pwr = CGPM_PM_SLOW;
					CGPM_REQ_DOWN:  next_pwr = CGPM_PM_DOWN;
					default:        next_pwr = CGPM_PM_ACTIVE;
				endcase
			end
			CGPM_PM_IDLE,
			CGPM_PM_SLOW: begin
				if (power_mode_req_in == CGPM_REQ_ACTIVE) begin
					next_pwr = CGPM_PM_ACTIVE;
				end
			end
			CGPM_PM_DOWN: begin
				if (wakeup_in) begin
					next_pwr = CGPM_PM_ACTIVE;
				end
			end
			default: begin
				next_pwr = CGPM_PM_ACTIVE;
			end
		endcase
	end

	// ****************************************
	// derived clock enables
	// ****************************************
	logic       cpu_tick;
	logic       slow_tick;
	logic [7:0] slow_factor;
	logic       sys_run;
	logic       out_tick;

	// no system clock while oscillator and pll are off
	assign sys_run = (power_mode_out != CGPM_PM_DOWN);
	assign slow_factor = (power_mode_out == CGPM_PM_SLOW) ?
		ctrl_in.slowdown_factor_field : CGPM_FACT_RESET;

	// cpu and peripheral rate is a third of system clock
	cgpm_divider #(.WIDTH(CGPM_CNT_W)) u_cpu_div (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.tick_in     (sys_run),
		.factor_in   (8'(CPU_DIV)),
		.en_out      (cpu_tick)
	);

	// slow-down divider changes factor only at period end
	cgpm_divider #(.WIDTH(CGPM_CNT_W)) u_slow_div (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.tick_in     (cpu_tick),
		.factor_in   (slow_factor),
		.en_out      (slow_tick)
	);

	cgpm_clk_en_s next_en;
	always_comb begin
		// flash fast clocks at full system rate
		next_en.flash_fast_clock_a_en = sys_run;
		next_en.flash_fast_clock_b_en = sys_run;
		next_en.periph_clock_en       = slow_tick;
		next_en.capture_unit_clock_en = slow_tick;
		// idle gates only the cpu
		// next state, so the first idle cycle already has no cpu pulse
		next_en.cpu_core_clock_en     = slow_tick && (next_pwr != CGPM_PM_IDLE);
	end

	// ****************************************
	// clock output pin
	// ****************************************
	logic next_pin;
	assign out_tick = (ctrl_in.clock_out_select == 2'h0) ? sys_run : cpu_tick;
	always_comb begin
		// toggle latch halves the rate, even duty
		if (ctrl_in.toggle_latch_enable) begin
			next_pin = out_tick ? !clock_output_pin_out : clock_output_pin_out;
		end else begin
			next_pin = out_tick;
		end
	end

	// ****************************************
	// supervision
	// ****************************************
	// lock loss set while powered and unlocked, held in power-down, cleared whenever pll locks
	cgpm_status_s next_stat;
	always_comb begin
		next_stat.osc_powered   = (next_pwr != CGPM_PM_DOWN);
		next_stat.pll_powered   = (next_pwr != CGPM_PM_DOWN);
		next_stat.osc_running   = osc_alive_in && sys_run;
		next_stat.pll_lock_lost = status_out.pll_lock_lost;
		if (sys_run && !pll_locked_in) begin
			next_stat.pll_lock_lost = 1'b1;
		end else if (pll_locked_in) begin
			next_stat.pll_lock_lost = 1'b0;
		end
	end

	logic next_flash_ok;
	// flash programming only at 80 MHz in pll mode, no slow-down
	assign next_flash_ok = (next_mode == CGPM_MODE_PLL) && (next_mult == 8'(CGPM_N_DEFAULT))
		&& (power_mode_out == CGPM_PM_ACTIVE) && !status_out.pll_lock_lost;

	// ****************************************
	// registers
	// ****************************************
	// reset enters active mode in pll mode
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clk_mode_out         <= CGPM_MODE_PLL;
			power_mode_out       <= CGPM_PM_ACTIVE;
			clk_en_out           <= '0;
			status_out           <= '0;
			sys_mult_out         <= 8'(CGPM_N_DEFAULT);
			sys_div_out          <= 8'(CGPM_K_DIV);
			flash_prog_ok_out    <= 1'b0;
			clock_output_pin_out <= 1'b0;
		end else begin
			clk_mode_out         <= next_mode;
			power_mode_out       <= next_pwr;
			clk_en_out           <= next_en;
			status_out           <= next_stat;
			sys_mult_out         <= next_mult;
			sys_div_out          <= next_div;
			flash_prog_ok_out    <= next_flash_ok;
			clock_output_pin_out <= next_pin;
		end
	end

endmodule : cgpm_top
`default_nettype wire

// ### verif/cgpm_checker.sv
// port assertions for the clock generation and power-mode block
`timescale 1ns/1ps
`default_nettype none
module cgpm_checker
	import cgpm_pkg::*;
(
	input  wire logic           core_clk_in,
	input  wire logic           arst_n_in,
	input  wire cgpm_ctrl_s     ctrl_in,
	input  wire logic [1:0]     power_mode_req_in,
	input  wire logic           pll_locked_in,
	input  wire cgpm_clk_mode_e clk_mode_out,
	input  wire cgpm_pwr_e      power_mode_out,
	input  wire cgpm_clk_en_s   clk_en_out,
	input  wire cgpm_status_s   status_out,
	input  wire logic [7:0]     sys_mult_out,
	input  wire logic [7:0]     sys_div_out,
	input  wire logic           flash_prog_ok_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	// ****************************************
	// mode and divider relations
	// ****************************************
	a_mode_base: assert property (ctrl_in.oscillator_disconnect |=> clk_mode_out == CGPM_MODE_BASE)
		else $error("base mode not selected");
	a_mode_presc: assert property (!ctrl_in.oscillator_disconnect && ctrl_in.vco_bypass_select
		|=> clk_mode_out == CGPM_MODE_PRESCALE) else $error("prescaler mode not selected");
	a_mode_pll: assert property (!ctrl_in.oscillator_disconnect && !ctrl_in.vco_bypass_select
		|=> clk_mode_out == CGPM_MODE_PLL) else $error("pll mode not selected");
	a_div_fixed: assert property (sys_div_out == 8'h02) else $error("divider not fixed");
	a_flash_gate: assert property (flash_prog_ok_out
		|-> clk_mode_out == CGPM_MODE_PLL && sys_mult_out == 8'h10) else $error("flash ok off 80");
	// ****************************************
	// power modes and clock enables
	// ****************************************
	a_idle_entry: assert property (power_mode_out == CGPM_PM_ACTIVE
		&& power_mode_req_in == CGPM_REQ_IDLE |=> power_mode_out == CGPM_PM_IDLE)
		else $error("idle not entered");
	a_no_idle_slow: assert property (power_mode_out == CGPM_PM_IDLE
		&& power_mode_req_in == CGPM_REQ_SLOW |=> power_mode_out == CGPM_PM_IDLE)
		else $error("idle left for slow");
	a_idle_cpu: assert property (power_mode_out == CGPM_PM_IDLE
		|-> !clk_en_out.cpu_core_clock_en) else $error("cpu clock in idle");
	// a shortened gap would be a shortened module clock pulse
	a_per_gap: assert property (clk_en_out.periph_clock_en
		|=> !clk_en_out.periph_clock_en [*2]) else $error("peripheral pulse gap short");
	a_cpu_gap: assert property (clk_en_out.cpu_core_clock_en
		|=> !clk_en_out.cpu_core_clock_en [*2]) else $error("cpu pulse gap short");
	a_down_off: assert property (power_mode_out == CGPM_PM_DOWN [*2]
		|-> !status_out.osc_powered && !status_out.pll_powered) else $error("power on in down");
	a_lock_lost: assert property (!pll_locked_in && power_mode_out != CGPM_PM_DOWN
		|=> status_out.pll_lock_lost) else $error("lock loss missed");
endmodule : cgpm_checker
`default_nettype wire

// ### verif/cgpm_top_tb.sv
// self-checking bench for the clock generation and power-mode block
`timescale 1ns/1ps
`default_nettype none
module cgpm_top_tb
	import cgpm_pkg::*;
;
	logic           clk, rst_n, osc, lock, wake, fok, pin;
	logic [1:0]     req;
	logic [7:0]     mult, div;
	cgpm_ctrl_s     ctrl;
	cgpm_clk_mode_e mode;
	cgpm_pwr_e      pwr;
	cgpm_clk_en_s   en;
	cgpm_status_s   st;
	int             n_errors, tests_run, n_cpu, n_per, n_pin, n_cap, n_fast;

	cgpm_top dut (.core_clk_in(clk), .arst_n_in(rst_n), .ctrl_in(ctrl),
		.power_mode_req_in(req), .osc_alive_in(osc), .pll_locked_in(lock),
		.wakeup_in(wake), .clk_mode_out(mode), .power_mode_out(pwr), .clk_en_out(en),
		.status_out(st), .sys_mult_out(mult), .sys_div_out(div),
		.flash_prog_ok_out(fok), .clock_output_pin_out(pin));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask : step
	// pulses and pin edges over n cycles; phase-free when n is a multiple of the period
	task automatic count(input int n);
		logic last;
		n_cpu = 0;
		n_per = 0;
		n_pin = 0;
		n_cap = 0;
		n_fast = 0;
		last = pin;
		repeat (n) begin
			step(1);
			n_cpu += int'(en.cpu_core_clock_en);
			n_per += int'(en.periph_clock_en);
			n_cap += int'(en.capture_unit_clock_en);
			n_fast += int'(en.flash_fast_clock_a_en && en.flash_fast_clock_b_en);
			n_pin += int'(pin !== last);
			last = pin;
		end
	endtask : count
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		n_errors = 0;
		tests_run = 0;
		rst_n = 1'b0;
		{osc, lock, wake} = 3'h6;
		req = CGPM_REQ_ACTIVE;
		ctrl = '0;
		ctrl.feedback_divider_field = CGPM_FEEDBACK_DIVIDER_FIELD_RESET;
		ctrl.slowdown_factor_field = 8'h01;
		step(5);
		check("power", pwr, CGPM_PM_ACTIVE);
		check("mult", mult, 8'h10);
		rst_n = 1'b1;
		for (int i = 0; i < 4; i++) begin
			{ctrl.oscillator_disconnect, ctrl.vco_bypass_select} = i[1:0];
			step(2);
			check("mode", mode, i[1] ? CGPM_MODE_BASE : i[0] ? CGPM_MODE_PRESCALE : CGPM_MODE_PLL);
			check("mult", mult, i[1] ? 8'h00 : i[0] ? 8'h01 : 8'h10);
			check("div", div, CGPM_P_DIV * CGPM_K_DIV);
			check("flash ok", fok, i == 0);
		end
		{ctrl.oscillator_disconnect, ctrl.vco_bypass_select, ctrl.feedback_divider_field} = 6'h03;
		step(2);
		check("mult n24", mult, 8'h18);
		check("flash ok n24", fok, 1'b0);
		ctrl.feedback_divider_field = CGPM_FEEDBACK_DIVIDER_FIELD_RESET;
		{osc, lock} = 2'h0;
		step(2);
		check("osc running", st.osc_running, 1'b0);
		check("lock lost", st.pll_lock_lost, 1'b1);
		{osc, lock} = 2'h3;
		ctrl.toggle_latch_enable = 1'b1;
		step(2);
		check("lock back", st.pll_lock_lost, 1'b0);
		count(12);
		check("cpu active", n_cpu, 4);
		check("pin edges", n_pin, 12);
		check("cap active", n_cap, 4);
		check("fast active", n_fast, 12);
		ctrl.clock_out_select = 2'h1;
		count(12);
		check("pin cpu edges", n_pin, 4);
		req = CGPM_REQ_IDLE;
		step(2);
		check("idle", pwr, CGPM_PM_IDLE);
		req = CGPM_REQ_SLOW;
		count(12);
		check("idle kept", pwr, CGPM_PM_IDLE);
		check("cpu idle", n_cpu, 0);
		check("per idle", n_per, 4);
		check("cap idle", n_cap, 4);
		check("fast idle", n_fast, 12);
		req = CGPM_REQ_ACTIVE;
		step(2);
		ctrl.slowdown_factor_field = 8'h02;
		req = CGPM_REQ_SLOW;
		step(12);
		count(24);
		check("slow", pwr, CGPM_PM_SLOW);
		check("cpu slow", n_cpu, 4);
		check("per slow", n_per, 4);
		req = CGPM_REQ_ACTIVE;
		step(12);
		req = CGPM_REQ_DOWN;
		step(3);
		check("osc power", st.osc_powered, 1'b0);
		check("pll power", st.pll_powered, 1'b0);
		check("flash clk down", en.flash_fast_clock_a_en, 1'b0);
		req = CGPM_REQ_ACTIVE;
		step(3);
		check("down kept", pwr, CGPM_PM_DOWN);
		wake = 1'b1;
		step(2);
		wake = 1'b0;
		check("woken", pwr, CGPM_PM_ACTIVE);
		req = CGPM_REQ_SLOW;
		step(3);
		rst_n = 1'b0;
		req = CGPM_REQ_ACTIVE;
		step(2);
		check("reset power", pwr, CGPM_PM_ACTIVE);
		check("reset enables", en, 5'h00);
		rst_n = 1'b1;
		step(2);
		check("after reset", pwr, CGPM_PM_ACTIVE);
		check("after reset mode", mode, CGPM_MODE_PLL);
		step(4);
		stop_test();
	end
endmodule : cgpm_top_tb

bind cgpm_top cgpm_checker chk (.core_clk_in, .arst_n_in, .ctrl_in, .power_mode_req_in,
	.pll_locked_in, .clk_mode_out, .power_mode_out, .clk_en_out, .status_out,
	.sys_mult_out, .sys_div_out, .flash_prog_ok_out);
`default_nettype wire
